// >>> plcr_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - low-swing bit one selects reduced swing, zero full swing; resets zero, sticky
// - self-crosslink bit one allows a port to crosslink-train against itself
// - self-crosslink bit ignored while crosslink disable is one
// - speed control zero starts Gen2 after first L0 from Detect; one stays Gen1
// - speed control defaults one on upstream, zero on downstream; sticky
// - target width 0..3 is x1..x8, 7 maximum, 4..6 reserved, reset 7
// - a programmed width change applies only on the retrain request
// - target width returns to default when training passes through Detect
module plcr_regs (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   sticky_rst_n,
  input  wire logic                   is_upstream,
  input  wire logic                   crosslink_disable,
  input  wire logic                   link_retrain_request,
  input  wire logic                   ltssm_in_detect,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output plcr_pkg::plcr_phy_ctl_s     phy_ctl
);
  import plcr_pkg::*;

  // both channels decode the same word offsets; the two low address bits are ignored
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    return addr[11:2] == off[11:2];
  endfunction : addr_is

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data latched independently, response after both
  logic        aw_hold_q, w_hold_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  // both channels refuse while a response waits, so a second write cannot overrun it
  wire aw_take  = s_axi_awvalid & ~aw_hold_q & ~bvalid_q;
  wire w_take   = s_axi_wvalid & ~w_hold_q & ~bvalid_q;
  wire aw_have  = aw_hold_q | aw_take;
  wire w_have   = w_hold_q | w_take;
  wire wr_fire  = aw_have & w_have & ~bvalid_q;
  wire [11:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire wr_serdes = wr_fire & addr_is(wr_addr, PLCR_SERDES_OFF);
  wire wr_cfg    = wr_fire & addr_is(wr_addr, PLCR_CFG_OFF);
  wire wr_hit    = wr_serdes | wr_cfg;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_hold_q <= aw_have & ~wr_fire;
      w_hold_q  <= w_have & ~wr_fire;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PLCR_RESP_OKAY;
    // bresp stands with bvalid until bready drains it
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? PLCR_RESP_OKAY : PLCR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky fields survive the bus reset and clear only on sticky_rst_n
  logic       lse_q, scl_q, isc_q;
  logic [2:0] tlc_q;
  logic       isc_init_q;

  // byte lane 1 carries bit 8 and bit 13..14, lane 2 carries 19..21
  wire wr_lse = wr_serdes & wr_strb[1];
  wire wr_scl = wr_cfg & wr_strb[1];
  wire wr_tlc = wr_cfg & wr_strb[2];

  always_ff @(posedge aclk) begin
    if (!sticky_rst_n) begin
      lse_q      <= PLCR_LSE_RESET;
      scl_q      <= PLCR_SCL_RESET;
      isc_q      <= 1'b0;
      isc_init_q <= 1'b0;
    end else begin
      // port role is read once after the sticky reset, so software may override it later
      if (!isc_init_q) begin
        isc_q      <= is_upstream;
        isc_init_q <= 1'b1;
      end else if (wr_scl) begin
        isc_q <= wr_data[PLCR_ISC_BIT];
      end
      if (wr_lse) begin
        lse_q <= wr_data[PLCR_LSE_BIT];
      end
      if (wr_scl) begin
        scl_q <= wr_data[PLCR_SCL_BIT];
      end
    end
  end

  // detect wins over a same-cycle write: full retrain discards the target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tlc_q <= PLCR_TLC_RESET;
    end else if (ltssm_in_detect) begin
      tlc_q <= PLCR_TLC_RESET;
    end else if (wr_tlc) begin
      tlc_q <= wr_data[PLCR_TLC_MSB:PLCR_TLC_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the phy
  // registered so the phy sees the request after any same-cycle target write has landed
  logic width_apply_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      width_apply_q <= 1'b0;
    end else begin
      width_apply_q <= link_retrain_request;
    end
  end

  // reserved codes 4..6 are stored but never forwarded as a width change
  function automatic logic lane_code_legal(input logic [2:0] code);
    return (code <= PLCR_TLC_X8) || (code == PLCR_TLC_MAX);
  endfunction : lane_code_legal
  wire tlc_legal = lane_code_legal(tlc_q);

  always_comb begin
    phy_ctl                  = '0;
    phy_ctl.tx_low_swing     = lse_q;
    phy_ctl.self_xlink_allow = scl_q & ~crosslink_disable;
    phy_ctl.auto_gen2        = ~isc_q;
    phy_ctl.lane_target      = tlc_q;
    phy_ctl.width_apply      = width_apply_q & tlc_legal;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle to rvalid
  // reads have no side effects, so arready only waits for the previous answer to drain
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire rd_take   = s_axi_arvalid & ~rvalid_q;
  wire rd_serdes = addr_is(s_axi_araddr, PLCR_SERDES_OFF);
  wire rd_cfg    = addr_is(s_axi_araddr, PLCR_CFG_OFF);
  wire [31:0] serdes_word = 32'(lse_q) << PLCR_LSE_BIT;
  wire [31:0] cfg_word    = (32'(scl_q) << PLCR_SCL_BIT) | (32'(isc_q) << PLCR_ISC_BIT)
                          | (32'(tlc_q) << PLCR_TLC_LSB);
  // unmapped offsets read as zero and answer with an error
  wire [31:0] rd_word = rd_serdes ? serdes_word : (rd_cfg ? cfg_word : 32'h0000_0000);

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= PLCR_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_serdes | rd_cfg) ? PLCR_RESP_OKAY : PLCR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // bus checks pause while aresetn is low; sticky checks name their own reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  low_swing_out_a: assert property (
    wr_lse |=> phy_ctl.tx_low_swing == $past(s_axi_wvalid & ~w_hold_q ? s_axi_wdata[8]
                                                                     : w_data_q[8]))
    else $error("low swing output does not follow written bit");
  self_xlink_gate_a: assert property (
    (scl_q && !crosslink_disable) |-> phy_ctl.self_xlink_allow)
    else $error("self crosslink not allowed while enabled");
  xlink_disable_a: assert property (
    crosslink_disable |-> !phy_ctl.self_xlink_allow)
    else $error("self crosslink allowed while crosslink disabled");
  auto_gen2_a: assert property (
    (wr_scl && isc_init_q && sticky_rst_n)
      |=> phy_ctl.auto_gen2 == !$past(wr_data[PLCR_ISC_BIT]))
    else $error("auto gen2 disagrees with written speed control");
  width_read_a: assert property (
    (s_axi_rvalid && $past(rd_take && rd_cfg))
      |-> s_axi_rdata[PLCR_TLC_MSB:PLCR_TLC_LSB] == $past(tlc_q))
    else $error("target width readback wrong");
  width_apply_a: assert property (
    phy_ctl.width_apply |-> $past(link_retrain_request))
    else $error("width applied without retrain request");
  detect_revert_a: assert property (
    ltssm_in_detect |=> tlc_q == PLCR_TLC_RESET)
    else $error("target width not restored after detect");
  reserved_zero_a: assert property (
    s_axi_rvalid |-> (s_axi_rdata & 32'hFFC0_9EFF) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  bresp_hold_a: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  rd_latency_a: assert property (
    rd_take |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  write_answer_a: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write answer not one cycle after both channels");
  write_err_a: assert property (
    (wr_fire && !wr_hit) |=> s_axi_bresp == PLCR_RESP_SLVERR)
    else $error("unmapped write not answered with an error");
  read_err_zero_a: assert property (
    (s_axi_rvalid && s_axi_rresp == PLCR_RESP_SLVERR) |-> s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  write_ignored_a: assert property (
    (wr_fire && !wr_hit && isc_init_q && sticky_rst_n)
      |=> $stable({lse_q, scl_q, isc_q}))
    else $error("unmapped write changed a field");

  // field behaviour as seen by the phy
  speed_default_a: assert property (
    (!sticky_rst_n ##1 sticky_rst_n)
      |=> phy_ctl.auto_gen2 == !$past(is_upstream))
    else $error("speed control default does not follow port role");
  // aresetn alone must leave the sticky low-swing field untouched
  sticky_keep_a: assert property (
    disable iff (!sticky_rst_n)
    !wr_lse |=> $stable(phy_ctl.tx_low_swing))
    else $error("low swing bit changed without a write");
  xlink_write_a: assert property (
    (wr_scl && sticky_rst_n)
      |=> crosslink_disable || phy_ctl.self_xlink_allow == $past(wr_data[PLCR_SCL_BIT]))
    else $error("self crosslink does not follow written bit");
  width_write_a: assert property (
    (wr_tlc && !ltssm_in_detect)
      |=> phy_ctl.lane_target == $past(wr_data[PLCR_TLC_MSB:PLCR_TLC_LSB]))
    else $error("target width does not hold written code");
  width_legal_a: assert property (
    phy_ctl.width_apply
      |-> (phy_ctl.lane_target <= PLCR_TLC_X8) || (phy_ctl.lane_target == PLCR_TLC_MAX))
    else $error("reserved target width forwarded to the phy");
  retrain_apply_a: assert property (
    (link_retrain_request && !wr_tlc && lane_code_legal(tlc_q))
      |=> phy_ctl.width_apply)
    else $error("legal target width not applied on retrain");

  // main scenarios
  cov_sticky_down_c: cover property (!sticky_rst_n ##1 (sticky_rst_n && !is_upstream));
  cov_width_write_c: cover property (wr_tlc ##[1:20] phy_ctl.width_apply);
  cov_detect_c:      cover property (wr_tlc ##[1:20] ltssm_in_detect);
  cov_low_swing_c:   cover property (wr_lse && wr_data[PLCR_LSE_BIT]);
  cov_unmapped_c:    cover property (wr_fire && !wr_hit);
endmodule : plcr_regs

// >>> plcr_pkg.sv
package plcr_pkg;
  localparam logic [11:0] PLCR_SERDES_OFF  = 12'h500;
  localparam logic [11:0] PLCR_CFG_OFF     = 12'h530;
  localparam int          PLCR_LSE_BIT     = 8;
  localparam int          PLCR_SCL_BIT     = 13;
  localparam int          PLCR_ISC_BIT     = 14;
  localparam int          PLCR_TLC_LSB     = 19;
  localparam int          PLCR_TLC_MSB     = 21;
  localparam logic [2:0]  PLCR_TLC_RESET   = 3'h7;
  localparam logic [2:0]  PLCR_TLC_MAX     = 3'h7;
  localparam logic [2:0]  PLCR_TLC_X8      = 3'h3;
  localparam logic        PLCR_LSE_RESET   = 1'h0;
  localparam logic        PLCR_SCL_RESET   = 1'h0;
  localparam logic [1:0]  PLCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PLCR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       tx_low_swing;
    logic       self_xlink_allow;
    logic       auto_gen2;
    logic [2:0] lane_target;
    logic       width_apply;
  } plcr_phy_ctl_s;
endpackage : plcr_pkg

// >>> tb_phy_link_config_regs.sv
`timescale 1ns/1ns
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_phy_link_config_regs;
  import plcr_pkg::*;
  logic          aclk = 0, aresetn = 0, sticky_rst_n = 0, is_upstream = 1;
  logic          crosslink_disable = 0, link_retrain_request = 0, ltssm_in_detect = 0;
  logic [11:0]   s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]   s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]    s_axi_wstrb = 4'hF;
  logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic          s_axi_arvalid = 0, s_axi_rready = 0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
  plcr_phy_ctl_s phy_ctl;
  int            mismatches = 0, checks = 0;
  plcr_regs dut_u (.aclk, .aresetn, .sticky_rst_n, .is_upstream, .crosslink_disable,
    .link_retrain_request, .ltssm_in_detect, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_ctl);
  always #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  // handshakes are judged at the falling edge so no race with the design's flops
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw, pb, ta, tw, tk;
    pa = 1; pw = 1; pb = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pa | pw | pb) begin
      @(negedge aclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      tk = pb & s_axi_bvalid;
      if (tk) rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) begin pa = 0; s_axi_awvalid <= 1'h0; end
      if (tw) begin pw = 0; s_axi_wvalid <= 1'h0; end
      if (tk) begin pb = 0; s_axi_bready <= 1'h0; end
    end
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [11:0] a);
    logic pa, pr, ta, tr;
    pa = 1; pr = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (pa | pr) begin
      @(negedge aclk);
      ta = pa & s_axi_arready;
      tr = pr & s_axi_rvalid;
      if (tr) begin rd = s_axi_rdata; rs = s_axi_rresp; end
      @(posedge aclk);
      if (ta) begin pa = 0; s_axi_arvalid <= 1'h0; end
      if (tr) begin pr = 0; s_axi_rready <= 1'h0; end
    end
    @(posedge aclk);
  endtask : axr
  task automatic cyc(); @(posedge aclk); endtask : cyc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    axr(PLCR_SERDES_OFF); `CHK("swing reg", 32'h0, rd)
    axr(PLCR_CFG_OFF); `CHK("cfg reg", 32'h00384000, rd)
    `CHK("lane target", 3'h7, phy_ctl.lane_target)
    `CHK("auto gen2 up", 1'h0, phy_ctl.auto_gen2)
  endtask : t_reset
  task automatic t_regs();
    axw(PLCR_SERDES_OFF, 32'hFFFFFFFF); `CHK("bresp", PLCR_RESP_OKAY, rs)
    axr(PLCR_SERDES_OFF); `CHK("swing rd", 32'h00000100, rd)
    `CHK("low swing", 1'h1, phy_ctl.tx_low_swing)
    axw(PLCR_CFG_OFF, 32'hFFFFFFFF);
    axr(PLCR_CFG_OFF); `CHK("cfg rd", 32'h00386000, rd)
    `CHK("xlink on", 1'h1, phy_ctl.self_xlink_allow)
    `CHK("gen1 stay", 1'h0, phy_ctl.auto_gen2)
    crosslink_disable <= 1'h1;
    cyc(); @(negedge aclk); `CHK("xlink gated", 1'h0, phy_ctl.self_xlink_allow)
    cyc(); crosslink_disable <= 1'h0;
    axw(PLCR_CFG_OFF, 32'h00002000); `CHK("gen2 auto", 1'h1, phy_ctl.auto_gen2)
    axw(PLCR_SERDES_OFF, 32'h0); `CHK("full swing", 1'h0, phy_ctl.tx_low_swing)
  endtask : t_regs
  task automatic t_width();
    for (int c = 0; c < 8; c++) begin
      axw(PLCR_CFG_OFF, {10'h0, 3'(c), 19'h0});
      @(negedge aclk); `CHK("no apply", 1'h0, phy_ctl.width_apply)
      `CHK("target", 3'(c), phy_ctl.lane_target)
      cyc(); link_retrain_request <= 1'h1;
      cyc(); link_retrain_request <= 1'h0;
      @(negedge aclk); `CHK("apply", 1'(c < 4 || c == 7), phy_ctl.width_apply)
      cyc();
    end
  endtask : t_width
  task automatic t_detect();
    axw(PLCR_CFG_OFF, 32'h00088000);
    ltssm_in_detect <= 1'h1;
    cyc(); ltssm_in_detect <= 1'h0;
    axr(PLCR_CFG_OFF); `CHK("detect rd", 3'h7, rd[21:19])
    `CHK("detect tgt", 3'h7, phy_ctl.lane_target)
  endtask : t_detect
  task automatic t_unmapped();
    axw(12'h504, 32'hFFFFFFFF); `CHK("wr err", PLCR_RESP_SLVERR, rs)
    axr(12'h504); `CHK("rd err", PLCR_RESP_SLVERR, rs)
    `CHK("rd err data", 32'h0, rd)
  endtask : t_unmapped
  task automatic t_sticky();
    axw(PLCR_SERDES_OFF, 32'h00000100);
    axw(PLCR_CFG_OFF, 32'h0008E000);
    aresetn <= 1'h0;
    cyc(); aresetn <= 1'h1;
    cyc(); axr(PLCR_SERDES_OFF); `CHK("sticky swing", 32'h00000100, rd)
    axr(PLCR_CFG_OFF); `CHK("width reset", 32'h00386000, rd)
    // second sticky reset as a downstream port
    sticky_rst_n <= 1'h0;
    is_upstream <= 1'h0;
    cyc(); sticky_rst_n <= 1'h1;
    cyc(); cyc(); axr(PLCR_CFG_OFF); `CHK("down dflt", 32'h00380000, rd)
    axr(PLCR_SERDES_OFF); `CHK("swing clr", 32'h0, rd)
  endtask : t_sticky
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    sticky_rst_n <= 1'h1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_regs();
    t_width();
    t_detect();
    t_unmapped();
    t_sticky();
    complete_run();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule : tb_phy_link_config_regs
